// File: verilog/msc_pkg.sv
/*
 * constants, register map and carrier types for the metering status and
 * check register bank.
 * assumes a serial front end that decodes register reads and writes and
 * reports the data bytes it moves; all registers here are read-only.
 */
package msc_pkg;

  // ***********************************************************
  // register offsets
  // ***********************************************************
  localparam logic [6:0] MSC_OFS_FLAGS    = 7'h42;
  localparam logic [6:0] MSC_OFS_STATUS   = 7'h43;
  localparam logic [6:0] MSC_OFS_RDCHK    = 7'h44;
  localparam logic [6:0] MSC_OFS_WRCHK    = 7'h45;
  localparam logic [6:0] MSC_OFS_EN_B     = 7'h6f;
  localparam logic [6:0] MSC_OFS_RMS_IA   = 7'h70;
  localparam logic [6:0] MSC_OFS_RMS_IB   = 7'h71;
  localparam logic [6:0] MSC_OFS_RMS_U    = 7'h72;
  localparam logic [6:0] MSC_OFS_PWR_A    = 7'h73;
  localparam logic [6:0] MSC_OFS_PWR_B    = 7'h75;
  localparam logic [6:0] MSC_OFS_PWR_S    = 7'h76;
  localparam logic [6:0] MSC_OFS_EN_A     = 7'h77;

  // ***********************************************************
  // field positions and reset values
  // ***********************************************************
  localparam int          MSC_ST_CLKSEL   = 6;
  localparam int          MSC_ST_UNLOCK   = 4;
  localparam int          MSC_ST_RESET    = 0;
  localparam logic [15:0] MSC_FLAG_VALID  = 16'hffdf;  // bit 5 reserved
  localparam logic [15:0] MSC_FLAGS_RST   = 16'h0000;
  localparam logic [31:0] MSC_RDCHK_RST   = 32'h0000_0000;
  localparam logic [15:0] MSC_WRCHK_RST   = 16'h0000;
  localparam logic [15:0] MSC_COEF_RST    = 16'hffff;
  localparam logic [15:0] MSC_SUM_SEED    = 16'hffff;
  localparam int          MSC_NCOEF       = 8;

  // ***********************************************************
  // carrier types
  // ***********************************************************
  // register access from the serial front end, one-cycle strobes
  typedef struct packed {
    logic       rd;
    logic [6:0] addr;
  } msc_rdreq_t;

  // one data byte moved over the link, one-cycle strobe
  typedef struct packed {
    logic       vld;
    logic [7:0] data;
  } msc_byte_t;

  // coefficient load from the one-time memory
  typedef struct packed {
    logic        vld;
    logic [2:0]  idx;
    logic [15:0] data;
  } msc_otp_t;

endpackage

// File: verilog/msc_regs.sv
/*
 * metering status and check register bank: shadow interrupt flags, system
 * status, read and write check copies, and conversion coefficients.
 * assumes the serial front end pulses a read request with the register
 * offset, a byte strobe for each data byte sent and received, and that the
 * one-time memory loader pulses one word per coefficient after reset.
 */
`timescale 1ns/1ps

module msc_regs
  import msc_pkg::*;
#(
  parameter int NEV = 16
)
(
  // clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              RST,
  // reset causes and system state
  input  wire logic              RESET_CAUSE,
  input  wire logic              CLK_INTERNAL,
  input  wire logic              WRITE_UNLOCK,
  // interrupt events and enables
  input  wire logic [NEV-1:0]    EVENTS,
  input  wire logic [NEV-1:0]    INTERRUPT_ENABLE_MASK,
  // serial front end and one-time memory loads
  input  wire msc_rdreq_t        RD_REQ,
  input  wire msc_byte_t         TX_BYTE,
  input  wire msc_byte_t         RX_BYTE,
  input  wire logic              STANDBY_LOAD,
  input  wire logic [15:0]       STANDBY_OTP,
  input  wire msc_otp_t          OTP_WORD,
  // read data and status out
  output logic [31:0]            RD_DATA,
  output logic [15:0]            PRIMARY_FLAGS,
  output logic [15:0]            SHADOW_FLAGS,
  output logic [15:0]            CHECKSUM,
  output logic [15:0]            STANDBY_WORD,
  output logic                   IRQ_N
);

  // ***********************************************************
  // state
  // ***********************************************************
  logic [15:0] prim_q, prim_d;
  logic [15:0] shad_q, shad_d;
  logic [15:0] en_q;
  logic        rst_flag_q;
  logic [31:0] rdchk_q;
  logic [15:0] wrchk_q;
  logic [15:0] coef_q [MSC_NCOEF];
  logic [15:0] sum_q;
  logic [31:0] rd_data_q;
  logic [15:0] stby_q;
  logic        irq_n_q;

  // ***********************************************************
  // decode
  // ***********************************************************
  // map an offset to a coefficient slot; slot 8 means not a coefficient
  function automatic logic [3:0] coef_slot(input logic [6:0] a);
    case (a)
      MSC_OFS_RMS_IA: coef_slot = 4'h0;
      MSC_OFS_RMS_IB: coef_slot = 4'h1;
      MSC_OFS_RMS_U:  coef_slot = 4'h2;
      MSC_OFS_PWR_A:  coef_slot = 4'h3;
      MSC_OFS_PWR_B:  coef_slot = 4'h4;
      MSC_OFS_PWR_S:  coef_slot = 4'h5;
      MSC_OFS_EN_A:   coef_slot = 4'h6;
      MSC_OFS_EN_B:   coef_slot = 4'h7;
      default:        coef_slot = 4'h8;
    endcase
  endfunction

  wire         rd_flags  = RD_REQ.rd && (RD_REQ.addr == MSC_OFS_FLAGS);
  wire         rd_status = RD_REQ.rd && (RD_REQ.addr == MSC_OFS_STATUS);
  wire [3:0]   slot      = coef_slot(RD_REQ.addr);
  // events are gated by the enable mask; reserved bit never rises
  wire [15:0]  ev_gated  = EVENTS & INTERRUPT_ENABLE_MASK
                           & MSC_FLAG_VALID;
  // an enable bit dropping withdraws its pending flag
  wire [15:0]  en_drop   = en_q & ~INTERRUPT_ENABLE_MASK;

  // set wins over clear so a flag read never swallows a new event
  assign prim_d = ((prim_q & ~en_drop & ~{16{rd_flags}}) | ev_gated);
  assign shad_d = ((shad_q & ~en_drop & ~{16{rd_flags}})
                   | ev_gated);

  wire [7:0]   status_v;
  // fields placed by position; every other bit stays zero
  assign status_v = (8'(CLK_INTERNAL) << MSC_ST_CLKSEL)
                  | (8'(WRITE_UNLOCK) << MSC_ST_UNLOCK)
                  | (8'(rst_flag_q) << MSC_ST_RESET);

  // checksum over the loaded coefficients, seeded with all ones
  logic [15:0] sum_d;
  always_comb
  begin
    sum_d = MSC_SUM_SEED;
    for (int i = 0; i < MSC_NCOEF; i++)
    begin
      sum_d = sum_d + coef_q[i];
    end
    sum_d = ~sum_d;
  end

  // read mux; coefficients are plain unsigned 16-bit words
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (slot != 4'h8)
      rd_mux = {16'h0000, coef_q[slot[2:0]]};
    else
    begin
      case (RD_REQ.addr)
        MSC_OFS_FLAGS:  rd_mux = {16'h0000, shad_q};
        MSC_OFS_STATUS: rd_mux = {24'h00_0000, status_v};
        MSC_OFS_RDCHK:  rd_mux = rdchk_q;
        MSC_OFS_WRCHK:  rd_mux = {16'h0000, wrchk_q};
        default:        rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // ***********************************************************
  // flags and interrupt pin
  // ***********************************************************
  // flag pair updates together so both clear on the same read
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      prim_q  <= MSC_FLAGS_RST;
      shad_q  <= MSC_FLAGS_RST;
      en_q    <= 16'h0000;
      irq_n_q <= 1'b1;
    end
    else
    begin
      prim_q  <= prim_d;
      shad_q  <= shad_d;
      en_q    <= INTERRUPT_ENABLE_MASK;
      irq_n_q <= ~(|prim_d);
    end
  end

  // ***********************************************************
  // reset sign
  // ***********************************************************
  // comes up set after any reset; a cause in the same cycle beats the clearing read
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      rst_flag_q <= 1'b1;
    else if (RESET_CAUSE)
      rst_flag_q <= 1'b1;
    else if (rd_status)
      rst_flag_q <= 1'b0;
  end

  // ***********************************************************
  // check copies
  // ***********************************************************
  // shift registers: newest byte enters at the low end
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      rdchk_q <= MSC_RDCHK_RST;
      wrchk_q <= MSC_WRCHK_RST;
    end
    else
    begin
      if (TX_BYTE.vld)
        rdchk_q <= {rdchk_q[23:0], TX_BYTE.data};
      if (RX_BYTE.vld)
        wrchk_q <= {wrchk_q[7:0], RX_BYTE.data};
    end
  end

  // ***********************************************************
  // coefficients from one-time memory
  // ***********************************************************
  // a blank part never loads, so the all-ones reset value stands
  genvar g;
  generate
    for (g = 0; g < MSC_NCOEF; g++)
    begin : g_coef
      always_ff @(posedge CORE_CLK or posedge RST)
      begin
        if (RST)
          coef_q[g] <= MSC_COEF_RST;
        else if (OTP_WORD.vld && (OTP_WORD.idx == 3'(g)))
          coef_q[g] <= OTP_WORD.data;
      end
    end
  endgenerate

  // ***********************************************************
  // registered outputs
  // ***********************************************************
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      rd_data_q <= 32'h0000_0000;
      sum_q     <= 16'h0000;
      stby_q    <= 16'h0000;
    end
    else
    begin
      if (RD_REQ.rd)
        rd_data_q <= rd_mux;
      sum_q <= sum_d;
      if (STANDBY_LOAD)
        stby_q <= STANDBY_OTP;
    end
  end

  assign RD_DATA       = rd_data_q;
  assign PRIMARY_FLAGS = prim_q;
  assign SHADOW_FLAGS  = shad_q;
  assign CHECKSUM      = sum_q;
  assign STANDBY_WORD  = stby_q;
  assign IRQ_N         = irq_n_q;

endmodule

// File: bench/msc_regs_assertions.sv
/* checker for the status and check register bank.
   assumes it is bound to msc_regs and sees only its ports. */
`timescale 1ns/1ps
module msc_regs_assertions
  import msc_pkg::*;
#(
  parameter int NEV = 16
)
(
  // clock, reset and inputs
  input wire logic           CORE_CLK,
  input wire logic           RST,
  input wire logic           RESET_CAUSE,
  input wire logic           CLK_INTERNAL,
  input wire logic           WRITE_UNLOCK,
  input wire logic [NEV-1:0] EVENTS,
  input wire logic [NEV-1:0] INTERRUPT_ENABLE_MASK,
  input wire msc_rdreq_t     RD_REQ,
  // outputs watched
  input wire logic [31:0]    RD_DATA,
  input wire logic [15:0]    PRIMARY_FLAGS,
  input wire logic [15:0]    SHADOW_FLAGS,
  input wire logic           IRQ_N
);
  // ****************************************
  // decoded requests and properties
  // ****************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // named decodes keep the properties short
  wire           rd_flg = RD_REQ.rd && RD_REQ.addr == MSC_OFS_FLAGS;
  wire           rd_st  = RD_REQ.rd && RD_REQ.addr == MSC_OFS_STATUS;
  wire [NEV-1:0] hit    = EVENTS & INTERRUPT_ENABLE_MASK;
  sequence s_st_read;
    rd_st && !RESET_CAUSE;
  endsequence
  property p_rd_clear;
    rd_flg && hit == '0 |=> SHADOW_FLAGS == '0 && PRIMARY_FLAGS == '0;
  endproperty
  property p_set;
    hit != '0 |=> (SHADOW_FLAGS & MSC_FLAG_VALID & $past(hit))
                  == (MSC_FLAG_VALID & $past(hit));
  endproperty
  property p_mask;
    1 |=> (SHADOW_FLAGS & ~$past(SHADOW_FLAGS)
           & ~$past(INTERRUPT_ENABLE_MASK)) == '0;
  endproperty
  property p_rsv;
    1 |-> !SHADOW_FLAGS[5] && !PRIMARY_FLAGS[5];
  endproperty
  property p_irq;
    1 |-> IRQ_N == (PRIMARY_FLAGS == '0);
  endproperty
  property p_status;
    rd_st |=> RD_DATA[6] == $past(CLK_INTERNAL)
      && RD_DATA[4] == $past(WRITE_UNLOCK)
      && (RD_DATA & 32'hffff_ffae) == '0;
  endproperty
  property p_st_clear;
    s_st_read ##1 !RESET_CAUSE ##1 s_st_read |=> !RD_DATA[0];
  endproperty
  property p_rst_sign;
    RESET_CAUSE ##1 rd_st |=> RD_DATA[0];
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("flag read did not clear both flag registers");
  a_set: assert property (p_set)
    else $error("enabled event did not set its shadow flag");
  a_mask: assert property (p_mask)
    else $error("flag rose without its enable bit");
  a_rsv: assert property (p_rsv)
    else $error("reserved flag bit is set");
  a_irq: assert property (p_irq)
    else $error("interrupt pin disagrees with primary flags");
  a_status: assert property (p_status)
    else $error("status read value wrong");
  a_st_clear: assert property (p_st_clear)
    else $error("reset sign not cleared by status read");
  a_rst_sign: assert property (p_rst_sign)
    else $error("reset sign not set by reset cause");
endmodule

// File: bench/msc_host.sv
/* host-side requester that reads the register bank.
   assumes the bench calls read from its own thread. */
`timescale 1ns/1ps
module msc_host
  import msc_pkg::*;
(
  // clock in, request out
  input  wire logic core_clk,
  output msc_rdreq_t rd_req
);
  // request idles low; a released address shows its inverse
  initial rd_req = '0;
  // one strobe, taken at the next rising edge; gap makes a slow host
  task automatic read(input logic [6:0] addr, input int gap);
    @(negedge core_clk);
    rd_req = {1'b1, addr};
    @(negedge core_clk);
    rd_req = {1'b0, ~addr};
    repeat (gap) @(negedge core_clk);
  endtask
endmodule

// File: bench/msc_regs_tb.sv
/* self-checking bench for the status and check register bank.
   assumes msc_regs, msc_host and the checker are compiled first. */
`timescale 1ns/1ps
module msc_regs_tb
  import msc_pkg::*;
;
  logic        clk = 0, rst = 1, cause = 0, clk_int = 1, unlock = 1;
  logic        sb_load = 0, irq_n;
  logic [15:0] ev = '0, mask = '0, sb_otp = '0, cks, shf, prf, sbw;
  logic [31:0] rdd;
  msc_rdreq_t  req;
  msc_byte_t   tx = '0, rx = '0;
  msc_otp_t    otp = '0;
  int          mismatches = 0, n_tests = 0, cyc = 0;
  logic [6:0]  ofs [8] = '{MSC_OFS_RMS_IA, MSC_OFS_RMS_IB, MSC_OFS_RMS_U,
    MSC_OFS_PWR_A, MSC_OFS_PWR_B, MSC_OFS_PWR_S, MSC_OFS_EN_A, MSC_OFS_EN_B};
  // ****************************************
  // clock, parts and shared tasks
  // ****************************************
  initial forever #10 clk = ~clk;
  msc_host msc_host_inst (.core_clk(clk), .rd_req(req));
  msc_regs #(.NEV(16)) msc_regs_inst (.CORE_CLK(clk), .RST(rst),
    .RESET_CAUSE(cause), .CLK_INTERNAL(clk_int), .WRITE_UNLOCK(unlock),
    .EVENTS(ev), .INTERRUPT_ENABLE_MASK(mask), .RD_REQ(req), .TX_BYTE(tx),
    .RX_BYTE(rx), .STANDBY_LOAD(sb_load), .STANDBY_OTP(sb_otp),
    .OTP_WORD(otp), .RD_DATA(rdd), .PRIMARY_FLAGS(prf), .SHADOW_FLAGS(shf),
    .CHECKSUM(cks), .STANDBY_WORD(sbw), .IRQ_N(irq_n));
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [31:0] exp);
    msc_host_inst.read(a, 0);
    chk($sformatf("read %h", a), exp, rdd);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // hang guard: the whole run needs about a hundred cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_status;
    rd(MSC_OFS_STATUS, 32'h51);
    rd(MSC_OFS_STATUS, 32'h50);
    @(negedge clk);
    clk_int = 0;
    unlock = 0;
    cause = 1;
    fork
      rd(MSC_OFS_STATUS, 32'h01);
      begin @(negedge clk); cause = 0; end
    join
    // a reset cause in the same cycle as the clearing read wins
    fork
      rd(MSC_OFS_STATUS, 32'h00);
      begin @(negedge clk); cause = 1; @(negedge clk); cause = 0; end
    join
    rd(MSC_OFS_STATUS, 32'h01);
    $display("test status done");
  endtask
  task automatic t_flags;
    @(negedge clk);
    mask = 16'hffff;
    ev = 16'hffff;
    @(negedge clk);
    ev = '0;
    chk("irq_n", 0, irq_n);
    chk("primary", 16'hffdf, prf);
    fork
      rd(MSC_OFS_FLAGS, 32'hffdf);
      begin @(negedge clk); ev = 16'h0001; @(negedge clk); ev = '0; end
    join
    chk("shadow kept", 16'h0001, shf);
    chk("primary kept", 16'h0001, prf);
    @(negedge clk);
    mask = 16'hfffe;
    ev = 16'h0003;
    @(negedge clk);
    ev = '0;
    @(negedge clk);
    chk("masked", 16'h0002, shf);
    rd(MSC_OFS_FLAGS, 32'h0002);
    chk("irq_n idle", 1, irq_n);
    rd(MSC_OFS_FLAGS, 32'h0000);
    $display("test flags done");
  endtask
  task automatic t_check;
    for (int i = 0; i < 5; i++)
    begin
      @(negedge clk);
      tx = {1'b1, 8'(8'h10 + i)};
      rx = {1'b1, 8'(8'h20 + i)};
      @(negedge clk);
      tx.vld = 0;
      rx.vld = 0;
    end
    rd(MSC_OFS_RDCHK, 32'h1112_1314);
    rd(MSC_OFS_WRCHK, 32'h0000_2324);
    rd(7'h00, 32'h0000_0000);
    $display("test check done");
  endtask
  task automatic t_coef(input logic [15:0] base, step);
    logic [15:0] s;
    s = 16'hffff;
    for (int i = 0; i < 8; i++)
    begin
      rd(ofs[i], {16'h0000, base + 16'(i) * step});
      s += base + 16'(i) * step;
    end
    chk("checksum", {16'h0000, ~s}, {16'h0000, cks});
    $display("test coefficients done");
  endtask
  task automatic t_otp;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk);
      otp = {1'b1, 3'(i), 16'h8000 + 16'(i) * 16'h1111};
      sb_otp = 16'h5a50 + 16'(i);
      sb_load = 1;
      @(negedge clk);
      otp.vld = 0;
      sb_load = 0;
    end
    chk("standby", 16'h5a57, sbw);
    $display("test otp done");
  endtask
  initial
  begin
    repeat (5) @(negedge clk);
    rst = 0;
    t_status();
    t_flags();
    t_check();
    t_coef(16'hffff, 16'h0000);
    t_otp();
    t_coef(16'h8000, 16'h1111);
    print_verdict();
  end
endmodule
bind msc_regs msc_regs_assertions #(.NEV(NEV)) msc_regs_assertions_inst (
  .CORE_CLK(CORE_CLK), .RST(RST), .RESET_CAUSE(RESET_CAUSE),
  .CLK_INTERNAL(CLK_INTERNAL), .WRITE_UNLOCK(WRITE_UNLOCK), .EVENTS(EVENTS),
  .INTERRUPT_ENABLE_MASK(INTERRUPT_ENABLE_MASK), .RD_REQ(RD_REQ),
  .RD_DATA(RD_DATA), .PRIMARY_FLAGS(PRIMARY_FLAGS),
  .SHADOW_FLAGS(SHADOW_FLAGS), .IRQ_N(IRQ_N));
